// ==== src/pwmr_pkg.sv ====
// constants of the dual-ramp pwm block with debug behaviour control
// assumes word-aligned apb access with 32-bit data
package pwmr_pkg;

	// ----------------------------------------
	// register indices, byte address = 4 * index
	// ----------------------------------------
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_PER = 8'h01;
	localparam logic [7:0] IDX_PER_B = 8'h02;
	localparam logic [7:0] IDX_CMP0 = 8'h03;
	localparam logic [7:0] IDX_CC1 = 8'h04;
	localparam logic [7:0] IDX_INT_STATUS = 8'h05;
	localparam logic [7:0] IDX_INT_MASK = 8'h06;
	localparam logic [7:0] IDX_COUNT = 8'h07;
	localparam logic [7:0] IDX_RUN_STATE = 8'h08;
	localparam logic [7:0] IDX_DEBUG_BEHAVIOUR_CONTROL = 8'h1e;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_SWRST = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_CIRC_PER = 4;
	localparam int CTRL_POL0 = 5;
	localparam int CTRL_POL1 = 6;
	localparam int CTRL_CAPT1 = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------
	// waveform modes
	// ----------------------------------------
	localparam logic [1:0] MODE_SINGLE_RAMP = 2'h0;
	localparam logic [1:0] MODE_DUAL_RAMP = 2'h1;
	localparam logic [1:0] MODE_ALT_DUAL_RAMP = 2'h2;

	// ----------------------------------------
	// debug behaviour control fields
	// ----------------------------------------
	localparam int DBG_RUN_WHILE_HALTED = 0;
	localparam int DBG_FAULT_ON_HALT = 2;
	localparam logic [7:0] DBG_RESET = 8'h00;

	// ----------------------------------------
	// interrupt status and mask layout
	// ----------------------------------------
	localparam int INT_CYCLE_END = 0;
	localparam int INT_CAPTURE1 = 1;
	localparam int INT_DEBUG_FAULT = 2;
	localparam int INT_BITS = 3;
	localparam logic [2:0] INT_RESET = 3'h0;

	typedef enum logic [3:0] {
		PWMR_ST_OFF = 4'b0001,
		PWMR_ST_RUN = 4'b0010,
		PWMR_ST_HALT = 4'b0100,
		PWMR_ST_FAULT = 4'b1000
	} pwmr_state_t;

endpackage

// ==== src/pwmr_sync.sv ====
// two-stage synchroniser for asynchronous level inputs
// assumes inputs come from outside the pclk domain
`timescale 1ns/1ps
module pwmr_sync #(
	parameter int N = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [N-1:0] async_in,
	output logic [N-1:0] sync_out
);
	logic [N-1:0] meta_q;

	if (N < 1)
	begin
		$error("pwmr_sync: N must be at least 1");
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ==== src/pwmr_top.sv ====
// apb slave, debug halt handling and capture of the dual-ramp pwm block
// assumes an apb master on pclk; debug halt and capture pins are asynchronous
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - in alternate dual-ramp mode with circular period buffering, compare channel 0 drives both waveform outputs.
// - in alternate dual-ramp mode both waveform outputs share the polarity of output 0.
// - in alternate dual-ramp mode with circular period buffering, channel 1 may capture while channel 0 makes both waveforms.
// - a software reset clears all timer state except the two debug-control bits.
// - with fault-on-debug-halt set, a debug halt while the timer is enabled raises a non-recoverable fault and sets the debug fault flag.
// - with fault-on-debug-halt clear, a debug halt never produces a fault.
// - with run-while-debug-halted clear, the timer halts during a debug halt.
// - with run-while-debug-halted set and fault-on-debug-halt clear, the timer keeps counting and generating during a debug halt.
// - debug-control holds fault-on-debug-halt at bit 2 and run-while-debug-halted at bit 0, resets to zero.
// - dual-ramp modes alternate cycle a (odd output off) and cycle b (even output off), index advancing each cycle.
module pwmr_top #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic debug_halt_req,
	input wire logic capture1_in,
	output logic [1:0] waveform_output,
	output logic nonrecoverable_fault,
	output logic irq
);
	import pwmr_pkg::*;

	if (W < 2 || W > 32)
	begin
		$error("pwmr_top: W must lie between 2 and 32");
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] idx);
		addr_is = (a[1:0] == 2'h0) && (a[7:2] == idx[5:0]);
	endfunction

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = addr_is(a, IDX_CTRL) || addr_is(a, IDX_PER) ||
			addr_is(a, IDX_PER_B) || addr_is(a, IDX_CMP0) || addr_is(a, IDX_CC1) ||
			addr_is(a, IDX_INT_STATUS) || addr_is(a, IDX_INT_MASK) ||
			addr_is(a, IDX_COUNT) || addr_is(a, IDX_RUN_STATE) ||
			addr_is(a, IDX_DEBUG_BEHAVIOUR_CONTROL);
	endfunction

	pwmr_wave_if #(.W(W)) wif ();

	logic [7:0] ctrl_q;
	logic [W-1:0] per_q;
	logic [W-1:0] per_b_q;
	logic [W-1:0] cmp0_q;
	logic [W-1:0] cc1_q;
	logic [INT_BITS-1:0] int_status_q;
	logic [INT_BITS-1:0] int_mask_q;
	logic [7:0] debug_behaviour_control_q;
	pwmr_state_t state_q;
	pwmr_state_t state_d;
	logic capt_prev_q;
	logic [1:0] sync_lvl;
	logic dbg_halt_s;
	logic capt_s;
	logic access;
	logic wr;
	logic rd;
	logic swrst;
	logic fault_cond;
	logic fault_exit;
	logic capture_evt;
	logic [INT_BITS-1:0] int_set;
	logic [31:0] rdata_d;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	pwmr_sync #(.N(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({capture1_in, debug_halt_req}),
		.sync_out(sync_lvl)
	);
	assign dbg_halt_s = sync_lvl[0];
	assign capt_s = sync_lvl[1];

	// ----------------------------------------
	// apb strobes
	// ----------------------------------------
	assign access = psel && penable && pready;
	assign wr = access && pwrite && addr_mapped(paddr);
	assign rd = access && !pwrite && addr_mapped(paddr);
	assign swrst = wr && addr_is(paddr, IDX_CTRL) && pwdata[CTRL_SWRST];

	// answer is given one cycle after setup, in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_mapped(paddr);
			prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0;
		end
	end

	always_comb
	begin
		rdata_d = 32'h0;
		if (addr_is(paddr, IDX_CTRL))
			rdata_d[7:0] = ctrl_q;
		else if (addr_is(paddr, IDX_PER))
			rdata_d[W-1:0] = per_q;
		else if (addr_is(paddr, IDX_PER_B))
			rdata_d[W-1:0] = per_b_q;
		else if (addr_is(paddr, IDX_CMP0))
			rdata_d[W-1:0] = cmp0_q;
		else if (addr_is(paddr, IDX_CC1))
			rdata_d[W-1:0] = cc1_q;
		else if (addr_is(paddr, IDX_INT_STATUS))
			rdata_d[INT_BITS-1:0] = int_status_q;
		else if (addr_is(paddr, IDX_INT_MASK))
			rdata_d[INT_BITS-1:0] = int_mask_q;
		else if (addr_is(paddr, IDX_COUNT))
			rdata_d[W-1:0] = wif.count;
		else if (addr_is(paddr, IDX_RUN_STATE))
			rdata_d[4:0] = {wif.ramp_idx, state_q};
		else if (addr_is(paddr, IDX_DEBUG_BEHAVIOUR_CONTROL))
			rdata_d[7:0] = debug_behaviour_control_q;
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= CTRL_RESET;
			per_q <= '1;
			per_b_q <= '1;
			cmp0_q <= '0;
		end
		else if (swrst)
		begin
			ctrl_q <= CTRL_RESET;
			per_q <= '1;
			per_b_q <= '1;
			cmp0_q <= '0;
		end
		else if (wr)
		begin
			if (addr_is(paddr, IDX_CTRL))
			begin
				ctrl_q <= pwdata[7:0];
				ctrl_q[CTRL_SWRST] <= 1'b0;
			end
			if (addr_is(paddr, IDX_PER))
				per_q <= pwdata[W-1:0];
			if (addr_is(paddr, IDX_PER_B))
				per_b_q <= pwdata[W-1:0];
			if (addr_is(paddr, IDX_CMP0))
				cmp0_q <= pwdata[W-1:0];
		end
	end

	// debug control survives software reset; only apb reset clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			debug_behaviour_control_q <= DBG_RESET;
		else if (wr && addr_is(paddr, IDX_DEBUG_BEHAVIOUR_CONTROL))
		begin
			debug_behaviour_control_q <= 8'h00;
			debug_behaviour_control_q[DBG_RUN_WHILE_HALTED] <= pwdata[DBG_RUN_WHILE_HALTED];
			debug_behaviour_control_q[DBG_FAULT_ON_HALT] <= pwdata[DBG_FAULT_ON_HALT];
		end
	end

	// ----------------------------------------
	// channel 1 compare or capture
	// ----------------------------------------
	assign capture_evt = ctrl_q[CTRL_CAPT1] && capt_s && !capt_prev_q &&
		(state_q == PWMR_ST_RUN);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			capt_prev_q <= 1'b0;
		else
			capt_prev_q <= capt_s;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cc1_q <= '0;
		else if (swrst)
			cc1_q <= '0;
		else if (capture_evt)
			cc1_q <= wif.count;
		else if (wr && addr_is(paddr, IDX_CC1) && !ctrl_q[CTRL_CAPT1])
			cc1_q <= pwdata[W-1:0];
	end

	// ----------------------------------------
	// run state
	// ----------------------------------------
	assign fault_cond = dbg_halt_s && debug_behaviour_control_q[DBG_FAULT_ON_HALT];
	assign fault_exit = wr && addr_is(paddr, IDX_CTRL) &&
		(!pwdata[CTRL_ENABLE] || pwdata[CTRL_SWRST]);

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			PWMR_ST_OFF:
				if (ctrl_q[CTRL_ENABLE])
					state_d = PWMR_ST_RUN;
			PWMR_ST_RUN:
				if (fault_cond)
					state_d = PWMR_ST_FAULT;
				else if (dbg_halt_s && !debug_behaviour_control_q[DBG_RUN_WHILE_HALTED])
					state_d = PWMR_ST_HALT;
			PWMR_ST_HALT:
				if (fault_cond)
					state_d = PWMR_ST_FAULT;
				else if (!dbg_halt_s || debug_behaviour_control_q[DBG_RUN_WHILE_HALTED])
					state_d = PWMR_ST_RUN;
			PWMR_ST_FAULT:
				state_d = PWMR_ST_FAULT;
			default:
				state_d = PWMR_ST_OFF;
		endcase
		if (!ctrl_q[CTRL_ENABLE])
			state_d = PWMR_ST_OFF;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= PWMR_ST_OFF;
		else if (swrst)
			state_q <= PWMR_ST_OFF;
		else
			state_q <= state_d;
	end

	// ----------------------------------------
	// waveform generator
	// ----------------------------------------
	assign wif.enable = state_q != PWMR_ST_OFF;
	assign wif.freeze = state_q == PWMR_ST_HALT;
	assign wif.fault = state_q == PWMR_ST_FAULT;
	assign wif.mode = ctrl_q[CTRL_MODE_LSB +: 2];
	assign wif.circ_per = ctrl_q[CTRL_CIRC_PER];
	assign wif.pol = {ctrl_q[CTRL_POL1], ctrl_q[CTRL_POL0]};
	assign wif.per = per_q;
	assign wif.per_b = per_b_q;
	assign wif.cmp0 = cmp0_q;
	assign wif.cc1 = cc1_q;

	pwmr_wave #(.W(W)) u_wave (
		.pclk(pclk),
		.presetn(presetn),
		.wif(wif)
	);

	assign waveform_output = wif.out_lvl;

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign int_set[INT_CYCLE_END] = wif.cycle_end;
	assign int_set[INT_CAPTURE1] = capture_evt;
	assign int_set[INT_DEBUG_FAULT] = (state_q != PWMR_ST_FAULT) &&
		(state_d == PWMR_ST_FAULT);

	// a read clears only the flags it returned; later events are kept
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_status_q <= INT_RESET;
		else if (swrst)
			int_status_q <= INT_RESET;
		else if (rd && addr_is(paddr, IDX_INT_STATUS))
			int_status_q <= (int_status_q & ~prdata[INT_BITS-1:0]) | int_set;
		else
			int_status_q <= int_status_q | int_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_mask_q <= INT_RESET;
		else if (swrst)
			int_mask_q <= INT_RESET;
		else if (wr && addr_is(paddr, IDX_INT_MASK))
			int_mask_q <= pwdata[INT_BITS-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
			nonrecoverable_fault <= 1'b0;
		end
		else
		begin
			irq <= |(int_status_q & int_mask_q);
			nonrecoverable_fault <= (state_q == PWMR_ST_FAULT) &&
				(state_d == PWMR_ST_FAULT) && !fault_exit;
		end
	end
endmodule

// ==== src/pwmr_wave.sv ====
// counter, ramp index and waveform outputs of the pwm block
// assumes control fields arrive from the top on the same clock
`timescale 1ns/1ps
module pwmr_wave #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	pwmr_wave_if.gen wif
);
	import pwmr_pkg::*;

	logic [W-1:0] period_now;
	logic at_top;
	logic run;
	logic lvl0;
	logic lvl1;
	logic pol1;

	// circular period buffer: cycle b uses the second period
	assign period_now = (wif.circ_per && wif.ramp_idx) ? wif.per_b : wif.per;
	assign at_top = wif.count >= period_now;
	assign run = wif.enable && !wif.freeze && !wif.fault;

	// ----------------------------------------
	// counter and ramp index
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wif.count <= '0;
			wif.ramp_idx <= 1'b0;
			wif.cycle_end <= 1'b0;
		end
		else
		begin
			wif.cycle_end <= run && at_top;
			if (!wif.enable)
			begin
				wif.count <= '0;
				wif.ramp_idx <= 1'b0;
			end
			else if (run)
			begin
				if (at_top)
				begin
					wif.count <= '0;
					wif.ramp_idx <= (wif.mode != MODE_SINGLE_RAMP) && !wif.ramp_idx;
				end
				else
					wif.count <= wif.count + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// waveform levels
	// ----------------------------------------
	always_comb
	begin
		lvl0 = wif.count < wif.cmp0;
		lvl1 = wif.count < wif.cc1;
		pol1 = wif.pol[1];
		unique case (wif.mode)
			MODE_DUAL_RAMP:
			begin
				lvl0 = lvl0 && !wif.ramp_idx;
				lvl1 = lvl1 && wif.ramp_idx;
			end
			MODE_ALT_DUAL_RAMP:
			begin
				if (wif.circ_per)
					lvl1 = lvl0;
				lvl0 = lvl0 && !wif.ramp_idx;
				lvl1 = lvl1 && wif.ramp_idx;
				pol1 = wif.pol[0];
			end
			default:
			begin
				lvl0 = lvl0;
				lvl1 = lvl1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wif.out_lvl <= 2'h0;
		else if (!wif.enable || wif.fault)
			wif.out_lvl <= 2'h0;
		else if (!wif.freeze)
			wif.out_lvl <= {lvl1 ^ pol1, lvl0 ^ wif.pol[0]};
	end
endmodule

// ==== src/pwmr_wave_if.sv ====
// carrier between the control top and the waveform generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pwmr_wave_if #(parameter int W = 16);
	logic enable;
	logic freeze;
	logic fault;
	logic [1:0] mode;
	logic circ_per;
	logic [1:0] pol;
	logic [W-1:0] per;
	logic [W-1:0] per_b;
	logic [W-1:0] cmp0;
	logic [W-1:0] cc1;
	logic [W-1:0] count;
	logic ramp_idx;
	logic cycle_end;
	logic [1:0] out_lvl;

	modport ctl (
		output enable, freeze, fault, mode, circ_per, pol, per, per_b, cmp0, cc1,
		input count, ramp_idx, cycle_end, out_lvl
	);
	modport gen (
		input enable, freeze, fault, mode, circ_per, pol, per, per_b, cmp0, cc1,
		output count, ramp_idx, cycle_end, out_lvl
	);
endinterface

// ==== testbench/pwmr_power_stage.sv ====
// power stage model driven by the two waveform outputs
// assumes outputs are registered levels on pclk
`timescale 1ns/1ps
module pwmr_power_stage (
	input wire logic pclk,
	input wire logic [1:0] lvl,
	input wire logic clr,
	output logic [7:0] hi0,
	output logic [7:0] hi1,
	output logic shoot
);
	// ----------------------------------------
	// switch on-time counters
	// ----------------------------------------
	always_ff @(posedge pclk)
	begin
		if (clr)
		begin
			hi0 <= 8'h00;
			hi1 <= 8'h00;
			shoot <= 1'b0;
		end
		else
		begin
			hi0 <= hi0 + {7'h00, lvl[0]};
			hi1 <= hi1 + {7'h00, lvl[1]};
			// both switches of a half bridge on at once
			if (lvl == 2'b11)
				shoot <= 1'b1;
		end
	end
endmodule

// ==== testbench/pwmr_top_sva.sv ====
// checker of the pwm top ports
// assumes single pclk domain, reset presetn
`timescale 1ns/1ps
module pwmr_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic debug_halt_req,
	input wire logic capture1_in,
	input wire logic [1:0] waveform_output,
	input wire logic nonrecoverable_fault,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc_w;
	logic acc_r;
	logic [2:0] dbg_q;
	logic en_q;
	logic [2:0] halt_q;
	assign acc_w = psel && penable && pready && pwrite;
	assign acc_r = psel && penable && pready && !pwrite;
	// ----------------------------------------
	// shadow of software settings and count of debug halt cycles
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dbg_q <= 3'h0;
			en_q <= 1'b0;
			halt_q <= 3'h0;
		end
		else
		begin
			if (acc_w && paddr == 8'h78)
				dbg_q <= {pwdata[2], 1'b0, pwdata[0]};
			if (acc_w && paddr == 8'h00)
				en_q <= pwdata[0] && !pwdata[1];
			if (!debug_halt_req)
				halt_q <= 3'h0;
			else if (halt_q != 3'h7)
				halt_q <= halt_q + 3'h1;
		end
	end
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no answer after setup");
	property p_rd0; !pready |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside access");
	property p_dbg_rd; acc_r && paddr == 8'h78 |-> prdata == {29'h0, dbg_q}; endproperty
	a_dbg_rd: assert property (p_dbg_rd) else $error("debug control readback");
	property p_freeze; halt_q == 3'h7 && !dbg_q[0] && !nonrecoverable_fault
		|=> $stable(waveform_output); endproperty
	a_freeze: assert property (p_freeze) else $error("outputs move in halt");
	property p_fault_rise; en_q && dbg_q[2] && halt_q == 3'h6 |-> nonrecoverable_fault;
	endproperty
	a_fault_rise: assert property (p_fault_rise) else $error("no fault on halt");
	property p_no_fault; !dbg_q[2] |-> !$rose(nonrecoverable_fault); endproperty
	a_no_fault: assert property (p_no_fault) else $error("fault while disabled");
	property p_cause; $rose(nonrecoverable_fault) |-> $past(debug_halt_req, 4); endproperty
	a_cause: assert property (p_cause) else $error("fault without halt");
	property p_hold; nonrecoverable_fault && !acc_w |=> nonrecoverable_fault; endproperty
	a_hold: assert property (p_hold) else $error("fault recovered alone");
	property p_off; nonrecoverable_fault |-> waveform_output == 2'b00; endproperty
	a_off: assert property (p_off) else $error("outputs on in fault");
	c_err: cover property (pslverr);
	c_freeze: cover property (halt_q == 3'h7 && !dbg_q[0]);
	c_fault: cover property ($rose(nonrecoverable_fault));
endmodule
bind pwmr_top pwmr_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .debug_halt_req(debug_halt_req),
	.capture1_in(capture1_in), .waveform_output(waveform_output),
	.nonrecoverable_fault(nonrecoverable_fault), .irq(irq));

// ==== testbench/test_pwm_alt_ramp_debug_control.sv ====
// self-checking bench of the dual-ramp pwm block
// assumes apb answers within a bounded wait
`timescale 1ns/1ps
module test_pwm_alt_ramp_debug_control;
	import pwmr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, halt = 0, cap = 0, clr = 0, irq, flt, shoot;
	logic [1:0] wav;
	logic [7:0] hi0, hi1;
	int errors = 0, samples_checked = 0;
	always #20 pclk = ~pclk;
	pwmr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .debug_halt_req(halt), .capture1_in(cap), .waveform_output(wav),
		.nonrecoverable_fault(flt), .irq(irq));
	pwmr_power_stage ps_u (.pclk(pclk), .lvl(wav), .clr(clr), .hi0(hi0), .hi1(hi1),
		.shoot(shoot));
	task conclude;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
		if (n >= 50)
			chk(1'b0, 1'b1);
	endtask
	task wait_c(input int n); repeat (n) @(posedge pclk); endtask
	task t_regs;
		apb(0, 8'h78, 0); chk(q, 32'h0);
		apb(1, 8'h78, 32'hff); apb(0, 8'h78, 0); chk(q, 32'h5);
		apb(0, 8'h3c, 0); chk(q, 32'h0);
		chk(e, 1'b1);
	endtask
	task t_swrst;
		apb(1, 8'h04, 32'h9); apb(1, 8'h00, 32'h1); apb(1, 8'h00, 32'h0);
		apb(1, 8'h00, 32'h2); apb(0, 8'h78, 0); chk(q, 32'h5);
		apb(0, 8'h00, 0); chk(q, 32'h0);
		apb(0, 8'h04, 0); chk(q, 32'hffff);
	endtask
	task t_halt(input logic [31:0] dbg);
		logic [31:0] c1;
		apb(1, 8'h78, dbg); apb(1, 8'h04, 32'h9); apb(1, 8'h0c, 32'h4);
		apb(1, 8'h00, 32'h1); wait_c(3);
		halt <= 1; wait_c(6);
		apb(0, 8'h1c, 0); c1 = q; wait_c(5); apb(0, 8'h1c, 0);
		chk(c1 !== q, dbg[0]);
		apb(0, 8'h20, 0); chk(q[3:0], dbg[0] ? 32'h2 : 32'h4);
		chk(flt, 1'b0);
		halt <= 0; apb(1, 8'h00, 32'h0);
	endtask
	task t_fault;
		apb(1, 8'h78, 32'h4); apb(1, 8'h18, 32'h4); apb(1, 8'h00, 32'h1);
		halt <= 1; wait_c(6); halt <= 0; wait_c(4);
		chk({flt, irq}, 2'b11);
		apb(1, 8'h18, 32'h0); wait_c(2); chk(irq, 1'b0);
		apb(1, 8'h18, 32'h4); wait_c(2); chk(irq, 1'b1);
		apb(0, 8'h14, 0); chk(q[2], 1'b1);
		wait_c(2); chk({flt, irq}, 2'b10);
		apb(1, 8'h00, 32'h0); wait_c(2); chk(flt, 1'b0);
		apb(1, 8'h78, 32'h0);
	endtask
	task t_alt;
		apb(1, 8'h04, 32'h7); apb(1, 8'h08, 32'h7); apb(1, 8'h0c, 32'h3);
		apb(1, 8'h10, 32'h20); apb(1, 8'h00, 32'h5); wait_c(20);
		clr <= 1; @(posedge pclk); clr <= 0; wait_c(17);
		chk({hi0, hi1}, 16'h0308);
		apb(1, 8'h00, 32'h59); wait_c(20);
		clr <= 1; @(posedge pclk); clr <= 0; wait_c(17);
		chk({hi0, hi1}, 16'h0303);
		chk(shoot, 1'b0);
		apb(1, 8'h00, 32'hd9); wait_c(3);
		cap <= 1; wait_c(4); cap <= 0; wait_c(4);
		apb(0, 8'h14, 0); chk(q[1], 1'b1);
		chk(q[0], 1'b1);
		apb(0, 8'h10, 0); chk(q < 32'h8, 1'b1);
		apb(1, 8'h00, 32'h0);
	endtask
	initial
	begin
		#(40 * 6000);
		errors++;
		conclude;
	end
	initial
	begin
		wait_c(20);
		presetn <= 1;
		t_regs;
		t_swrst;
		t_halt(32'h0);
		t_halt(32'h1);
		t_fault;
		t_alt;
		conclude;
	end
endmodule
